// ---- ceam_consts.svh ----
// constants of the communication error and alarm monitor
`ifndef CEAM_CONSTS_SVH
`define CEAM_CONSTS_SVH
`define CEAM_ERR_LINK 8'h84
`define CEAM_ERR_UNDEF 8'h88
`define CEAM_ERR_TOOL 8'h89
`define CEAM_ERR_NVBUSY 8'h8a
`define CEAM_ERR_RANGE 8'h8c
`define CEAM_ERR_STATE 8'h8d
`define CEAM_ALM_NONE 8'h00
`define CEAM_ALM_BUS 8'h81
`define CEAM_ALM_SWITCH 8'h83
`define CEAM_ALM_LINK 8'h84
`define CEAM_ALM_TIMEOUT 8'h85
`define CEAM_ALM_CONV 8'h8e
`define CEAM_HIST_DEPTH 10
`define CEAM_HIST_IDX_MAX 4'h9
`define CEAM_LINK_ERR_LIMIT 2'h3
`define CEAM_CLK_MHZ 200
`define CEAM_TIMEOUT_MS 200
`define CEAM_TIMEOUT_CYC (`CEAM_TIMEOUT_MS * 1000 * `CEAM_CLK_MHZ)
`define CEAM_BLINK_MS 100
`define CEAM_BLINK_CYC (`CEAM_BLINK_MS * 1000 * `CEAM_CLK_MHZ)
`define CEAM_BLINK_PHASES 3'h4
`endif

// ---- ceam_pkg.sv ----
// types of the communication error and alarm monitor
package ceam_pkg;
    typedef struct packed {
        logic framingErr;
        logic checkErr;
        logic undefCmd;
        logic rangeErr;
        logic stateErr;
    } ceam_frame_t;
    typedef struct packed {
        logic commRed;
        logic commGreen;
        logic supplyRed;
        logic supplyGreen;
    } ceam_led_t;
    typedef enum logic [2:0] {
        CEAM_IDLE = 3'b001,
        CEAM_ERRBLINK = 3'b010,
        CEAM_ALARM = 3'b100
    } ceam_led_state_t;
endpackage : ceam_pkg

// ---- ceam_history.sv ----
// ten-entry volatile error history, newest at index zero
`include "ceam_consts.svh"
module ceam_history (
    input wire logic clk,
    input wire logic srst,
    input wire logic push,
    input wire logic [7:0] pushCode,
    input wire logic clear,
    input wire logic [3:0] readIdx,
    output logic [7:0] readCode,
    output logic [3:0] count
);
    logic [7:0] entry_q [`CEAM_HIST_DEPTH];
    logic [3:0] count_q;
    // ************
    // shift storage
    // ************
    genvar i;
    generate
        for (i = 0; i < `CEAM_HIST_DEPTH; i++) begin : gEntry
            always_ff @(posedge clk) begin
                if (srst || clear) begin // [RULE_12] [RULE_13]
                    entry_q[i] <= 8'h00;
                end else if (push) begin
                    if (i == 0) begin
                        entry_q[i] <= pushCode;
                    end else begin
                        entry_q[i] <= entry_q[i-1]; // [RULE_10]
                    end
                end
            end
        end
    endgenerate
    always_ff @(posedge clk) begin
        if (srst || clear) begin
            count_q <= 4'h0;
        end else if (push && count_q != 4'(`CEAM_HIST_DEPTH)) begin
            count_q <= count_q + 4'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            readCode <= 8'h00;
        end else if (readIdx <= `CEAM_HIST_IDX_MAX && readIdx < count_q) begin
            readCode <= entry_q[readIdx]; // [RULE_11]
        end else begin
            readCode <= 8'h00;
        end
    end
    assign count = count_q;
endmodule : ceam_history

// ---- ceam_monitor.sv ----
// communication error classifier, alarm raiser and indicator driver
`include "ceam_consts.svh"
// Functional notes
// [RULE_01] link error lights comm indicator red
// [RULE_02] link error blinks supply red+green twice
// [RULE_03] other errors leave indicators unchanged
// [RULE_04] framing or check mismatch gives 84h
// [RULE_05] undefined command rejected with 88h
// [RULE_06] tool port busy refuses with 89h
// [RULE_07] busy flag or memory alarm gives 8Ah
// [RULE_08] out of range data gives 8Ch
// [RULE_09] command not executable now gives 8Dh
// [RULE_10] ten-entry history, newest first, oldest dropped
// [RULE_11] master reads stored history entries
// [RULE_12] master clear empties history; a clear in the same cycle as a rejected frame is ignored
// [RULE_13] history empty after power-up
// [RULE_14] alarm: fault outputs, motor stop, red blink
// [RULE_15] running with master disconnected raises 81h
// [RULE_16] bad bit-rate switch raises 83h
// [RULE_17] three successive link errors raise 84h
// [RULE_18] no link for 200 ms raises 85h
// [RULE_19] converter alarm raises 8Eh
// [RULE_20] timeout restarts on each valid frame
module ceam_monitor #(
    parameter int TIMEOUT_CYC = `CEAM_TIMEOUT_CYC,
    parameter int BLINK_CYC = `CEAM_BLINK_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic frameDone,
    input wire ceam_pkg::ceam_frame_t frameInfo,
    input wire logic toolPortActive,
    input wire logic internalBusyFlag,
    input wire logic nvMemAlarm,
    input wire logic motorRunning,
    input wire logic masterDisconnected,
    input wire logic baudSwitchValid,
    input wire logic converterAlarm,
    input wire logic histRead,
    input wire logic [3:0] histReadIdx,
    input wire logic histClear,
    input wire logic alarmReset,
    output logic cmdAccept,
    output logic cmdReject,
    output logic [7:0] errCode,
    output logic [7:0] histCode,
    output logic [3:0] histCount,
    output logic [7:0] alarmCode,
    output logic faultOutputActiveHigh,
    output logic faultOutputActiveLowN,
    output logic motorStop,
    output ceam_pkg::ceam_led_t commStatusIndicator,
    output ceam_pkg::ceam_led_t supplyFaultIndicator
);
    // ************
    // pin synchronisers
    // ************
    logic [6:0] pinMeta_q;
    logic [6:0] pinSync_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            pinMeta_q <= 7'h00;
            pinSync_q <= 7'h00;
        end else begin
            pinMeta_q <= {toolPortActive, internalBusyFlag, nvMemAlarm, motorRunning,
                          masterDisconnected, ~baudSwitchValid, converterAlarm};
            pinSync_q <= pinMeta_q;
        end
    end
    logic toolSync, busySync, nvSync, runSync, discSync, badBaudSync, convSync;
    assign {toolSync, busySync, nvSync, runSync, discSync, badBaudSync, convSync} = pinSync_q;

    // ************
    // error classification
    // ************
    logic [7:0] errCode_d;
    logic linkErr;
    always_comb begin
        linkErr = frameInfo.framingErr || frameInfo.checkErr;
        errCode_d = 8'h00;
        if (linkErr) begin
            errCode_d = `CEAM_ERR_LINK; // [RULE_04]
        end else if (frameInfo.undefCmd) begin
            errCode_d = `CEAM_ERR_UNDEF; // [RULE_05]
        end else if (toolSync) begin
            errCode_d = `CEAM_ERR_TOOL; // [RULE_06]
        end else if (busySync || nvSync) begin
            errCode_d = `CEAM_ERR_NVBUSY; // [RULE_07]
        end else if (frameInfo.rangeErr) begin
            errCode_d = `CEAM_ERR_RANGE; // [RULE_08]
        end else if (frameInfo.stateErr) begin
            errCode_d = `CEAM_ERR_STATE; // [RULE_09]
        end
    end
    logic frameBad;
    assign frameBad = frameDone && (errCode_d != 8'h00);
    always_ff @(posedge clk) begin
        if (srst) begin
            cmdAccept <= 1'b0;
            cmdReject <= 1'b0;
            errCode <= 8'h00;
        end else begin
            cmdAccept <= frameDone && !frameBad;
            cmdReject <= frameBad;
            if (frameBad) begin
                errCode <= errCode_d;
            end
        end
    end

    // ************
    // error history
    // ************
    logic [7:0] histData;
    ceam_history uHistory (
        .clk(clk),
        .srst(srst),
        .push(frameBad),
        .pushCode(errCode_d),
        .clear(histClear && !frameBad), // [RULE_12]
        .readIdx(histReadIdx),
        .readCode(histData),
        .count(histCount)
    );
    always_ff @(posedge clk) begin
        if (srst) begin
            histCode <= 8'h00;
        end else if (histRead) begin
            histCode <= histData; // [RULE_11]
        end
    end

    // ************
    // consecutive link errors and timeout
    // ************
    logic [1:0] linkErrCnt_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            linkErrCnt_q <= 2'h0;
        end else if (frameDone && linkErr) begin
            if (linkErrCnt_q != `CEAM_LINK_ERR_LIMIT) begin
                linkErrCnt_q <= linkErrCnt_q + 2'h1; // [RULE_17]
            end
        end else if (frameDone) begin
            linkErrCnt_q <= 2'h0; // [RULE_17]
        end
    end
    logic [31:0] toCnt_q;
    logic timeoutHit;
    assign timeoutHit = (toCnt_q >= 32'(TIMEOUT_CYC));
    always_ff @(posedge clk) begin
        if (srst) begin
            toCnt_q <= 32'h0;
        end else if (frameDone && !linkErr) begin
            toCnt_q <= 32'h0; // [RULE_20]
        end else if (!timeoutHit) begin
            toCnt_q <= toCnt_q + 32'h1; // [RULE_20]
        end
    end

    // ************
    // alarm latch
    // ************
    logic [7:0] alarmCode_d;
    always_comb begin
        alarmCode_d = `CEAM_ALM_NONE;
        if (badBaudSync) begin
            alarmCode_d = `CEAM_ALM_SWITCH; // [RULE_16]
        end else if (convSync) begin
            alarmCode_d = `CEAM_ALM_CONV; // [RULE_19]
        end else if (runSync && discSync) begin
            alarmCode_d = `CEAM_ALM_BUS; // [RULE_15]
        end else if (linkErrCnt_q == `CEAM_LINK_ERR_LIMIT) begin
            alarmCode_d = `CEAM_ALM_LINK; // [RULE_17]
        end else if (timeoutHit) begin
            alarmCode_d = `CEAM_ALM_TIMEOUT; // [RULE_18]
        end
    end
    logic alarmOn;
    assign alarmOn = (alarmCode != `CEAM_ALM_NONE);
    always_ff @(posedge clk) begin
        if (srst) begin
            alarmCode <= `CEAM_ALM_NONE;
        end else if (!alarmOn) begin
            alarmCode <= alarmCode_d;
        end else if (alarmReset && alarmCode_d == `CEAM_ALM_NONE) begin
            alarmCode <= `CEAM_ALM_NONE;
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            faultOutputActiveHigh <= 1'b0;
            faultOutputActiveLowN <= 1'b1;
            motorStop <= 1'b0;
        end else begin
            faultOutputActiveHigh <= alarmOn; // [RULE_14]
            faultOutputActiveLowN <= !alarmOn; // [RULE_14]
            motorStop <= alarmOn; // [RULE_14]
        end
    end

    // ************
    // indicators
    // ************
    ceam_pkg::ceam_led_state_t ledState_q;
    logic [31:0] blinkCnt_q;
    logic [2:0] phase_q;
    logic phaseEnd;
    logic commRed_q;
    assign phaseEnd = (blinkCnt_q >= 32'(BLINK_CYC - 1));
    always_ff @(posedge clk) begin
        if (srst) begin
            ledState_q <= ceam_pkg::CEAM_IDLE;
            blinkCnt_q <= 32'h0;
            phase_q <= 3'h0;
        end else begin
            blinkCnt_q <= phaseEnd ? 32'h0 : blinkCnt_q + 32'h1;
            unique case (ledState_q)
                ceam_pkg::CEAM_IDLE: begin
                    if (alarmOn) begin
                        ledState_q <= ceam_pkg::CEAM_ALARM;
                    end else if (frameDone && linkErr) begin
                        ledState_q <= ceam_pkg::CEAM_ERRBLINK; // [RULE_02]
                        blinkCnt_q <= 32'h0;
                        phase_q <= 3'h0;
                    end
                end
                ceam_pkg::CEAM_ERRBLINK: begin
                    if (alarmOn) begin
                        ledState_q <= ceam_pkg::CEAM_ALARM;
                    end else if (phaseEnd) begin
                        phase_q <= phase_q + 3'h1;
                        if (phase_q == `CEAM_BLINK_PHASES - 3'h1) begin
                            ledState_q <= ceam_pkg::CEAM_IDLE; // [RULE_02]
                        end
                    end
                end
                ceam_pkg::CEAM_ALARM: begin
                    if (!alarmOn) begin
                        ledState_q <= ceam_pkg::CEAM_IDLE;
                    end else if (phaseEnd) begin
                        phase_q <= phase_q + 3'h1;
                    end
                end
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            commRed_q <= 1'b0;
        end else if (frameDone && linkErr) begin
            commRed_q <= 1'b1; // [RULE_01] [RULE_03]
        end else if (frameDone && !frameBad) begin
            commRed_q <= 1'b0; // [RULE_03]
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            commStatusIndicator <= '0;
            supplyFaultIndicator <= '0;
        end else begin
            commStatusIndicator.commRed <= commRed_q; // [RULE_01]
            commStatusIndicator.commGreen <= !commRed_q && !alarmOn;
            commStatusIndicator.supplyRed <= 1'b0;
            commStatusIndicator.supplyGreen <= 1'b0;
            supplyFaultIndicator.commRed <= 1'b0;
            supplyFaultIndicator.commGreen <= 1'b0;
            unique case (ledState_q)
                ceam_pkg::CEAM_IDLE: begin
                    supplyFaultIndicator.supplyRed <= 1'b0;
                    supplyFaultIndicator.supplyGreen <= 1'b1;
                end
                ceam_pkg::CEAM_ERRBLINK: begin
                    supplyFaultIndicator.supplyRed <= !phase_q[0]; // [RULE_02]
                    supplyFaultIndicator.supplyGreen <= !phase_q[0]; // [RULE_02]
                end
                ceam_pkg::CEAM_ALARM: begin
                    supplyFaultIndicator.supplyRed <= !phase_q[0]; // [RULE_14]
                    supplyFaultIndicator.supplyGreen <= 1'b0;
                end
            endcase
        end
    end

    // ************
    // assertions
    // ************
    sequence sLinkErr;
        frameDone && linkErr;
    endsequence
    AST_LINK_CODE: assert property (@(posedge clk) disable iff (srst) // [RULE_04]
        sLinkErr |=> cmdReject && errCode == `CEAM_ERR_LINK)
        else $error("link error code wrong");
    AST_COMM_RED: assert property (@(posedge clk) disable iff (srst) // [RULE_01]
        sLinkErr |=> ##1 commStatusIndicator.commRed)
        else $error("comm indicator not red");
    AST_OTHER_NOLED: assert property (@(posedge clk) disable iff (srst) // [RULE_03]
        frameDone && !linkErr && ledState_q == ceam_pkg::CEAM_IDLE && !alarmOn
        |=> ledState_q == ceam_pkg::CEAM_IDLE)
        else $error("indicator changed on other error");
    AST_UNDEF: assert property (@(posedge clk) disable iff (srst) // [RULE_05]
        frameDone && !linkErr && frameInfo.undefCmd |=> errCode == `CEAM_ERR_UNDEF && !cmdAccept)
        else $error("undefined command not rejected");
    AST_TOOL: assert property (@(posedge clk) disable iff (srst) // [RULE_06]
        frameDone && !linkErr && !frameInfo.undefCmd && toolSync |=> errCode == `CEAM_ERR_TOOL)
        else $error("tool busy not refused");
    AST_FAULT_OUT: assert property (@(posedge clk) disable iff (srst) // [RULE_14]
        alarmOn |=> faultOutputActiveHigh && !faultOutputActiveLowN && motorStop)
        else $error("fault outputs wrong");
    AST_THREE_ERR: assert property (@(posedge clk) disable iff (srst) // [RULE_17]
        linkErrCnt_q == `CEAM_LINK_ERR_LIMIT && !alarmOn && !badBaudSync && !convSync
        && !(runSync && discSync) |=> alarmCode == `CEAM_ALM_LINK)
        else $error("link alarm not raised");
    AST_TIMEOUT_RST: assert property (@(posedge clk) disable iff (srst) // [RULE_20]
        frameDone && !linkErr |=> toCnt_q == 32'h0)
        else $error("timeout not restarted");
    AST_SWITCH: assert property (@(posedge clk) disable iff (srst) // [RULE_16]
        badBaudSync && !alarmOn |=> alarmCode == `CEAM_ALM_SWITCH)
        else $error("switch alarm missing");
endmodule : ceam_monitor

// ---- ceam_conv_model.sv ----
// converter-side frame source with keep-alive traffic
module ceam_conv_model (
    output logic frameDone,
    output ceam_pkg::ceam_frame_t frameInfo,
    input wire logic clk
);
    timeunit 1ns;
    timeprecision 100ps;
    logic pendReq = 1'b0;
    logic keepAlive = 1'b1;
    ceam_pkg::ceam_frame_t pendInfo = '0;
    int idleCnt = 0;
    initial begin
        frameDone = 1'b0;
        frameInfo = '0;
    end
    // requested frame first, else a good frame after every 19 idle cycles
    always @(negedge clk) begin
        idleCnt = idleCnt + 1;
        if (pendReq) begin
            frameDone <= 1'b1;
            frameInfo <= pendInfo;
            pendReq = 1'b0;
            idleCnt = 0;
        end else if (keepAlive && idleCnt >= 20) begin
            frameDone <= 1'b1;
            frameInfo <= '0;
            idleCnt = 0;
        end else begin
            frameDone <= 1'b0;
            frameInfo <= ~frameInfo;
        end
    end
    task automatic send(input ceam_pkg::ceam_frame_t info);
        pendInfo = info;
        pendReq = 1'b1;
    endtask : send
endmodule : ceam_conv_model

// ---- tb_comm_error_alarm_monitor.sv ----
// self-checking bench of the communication error and alarm monitor
module tb_comm_error_alarm_monitor;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic frameDone;
    ceam_pkg::ceam_frame_t frameInfo;
    logic toolPortActive = 1'b0, internalBusyFlag = 1'b0, nvMemAlarm = 1'b0;
    logic motorRunning = 1'b0, masterDisconnected = 1'b0, baudSwitchValid = 1'b1;
    logic converterAlarm = 1'b0, histRead = 1'b0, histClear = 1'b0, alarmReset = 1'b0;
    logic [3:0] histReadIdx = 4'h0;
    logic cmdAccept, cmdReject, faultHi, faultLoN, motorStop;
    logic [7:0] errCode, histCode, alarmCode;
    logic [3:0] histCount;
    ceam_pkg::ceam_led_t commLed, supplyLed;
    int mismatches = 0;
    int checksDone = 0;
    always #2.5 clk = ~clk;
    ceam_conv_model conv_u (.clk(clk), .frameDone(frameDone), .frameInfo(frameInfo));
    ceam_monitor #(.TIMEOUT_CYC(150), .BLINK_CYC(4)) dut_u (
        .clk(clk), .srst(srst), .frameDone(frameDone), .frameInfo(frameInfo),
        .toolPortActive(toolPortActive), .internalBusyFlag(internalBusyFlag),
        .nvMemAlarm(nvMemAlarm), .motorRunning(motorRunning),
        .masterDisconnected(masterDisconnected), .baudSwitchValid(baudSwitchValid),
        .converterAlarm(converterAlarm), .histRead(histRead), .histReadIdx(histReadIdx),
        .histClear(histClear), .alarmReset(alarmReset), .cmdAccept(cmdAccept),
        .cmdReject(cmdReject), .errCode(errCode), .histCode(histCode),
        .histCount(histCount), .alarmCode(alarmCode), .faultOutputActiveHigh(faultHi),
        .faultOutputActiveLowN(faultLoN), .motorStop(motorStop),
        .commStatusIndicator(commLed), .supplyFaultIndicator(supplyLed));
    // ****************************************
    // helper tasks
    // ****************************************
    task automatic final_report();
        $display("mismatches %0d, checks %0d", mismatches, checksDone);
        if (mismatches == 0 && checksDone > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        checksDone++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk
    task automatic send_frame(input ceam_pkg::ceam_frame_t info);
        @(posedge clk);
        #1;
        conv_u.send(info);
        @(negedge clk);
        @(posedge clk);
        #1;
    endtask : send_frame
    task automatic strobe(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask : strobe
    task automatic read_hist(input logic [3:0] idx, input logic [7:0] exp);
        @(negedge clk);
        histReadIdx = idx;
        @(negedge clk);
        histRead = 1'b1;
        @(negedge clk);
        histRead = 1'b0;
        @(posedge clk);
        @(posedge clk);
        #1;
        chk(histCode, exp, "history entry");
    endtask : read_hist
    task automatic wait_alarm(input logic [7:0] exp, input int bound);
        int i;
        for (i = 0; i < bound && alarmCode !== exp; i++) begin
            @(posedge clk);
            #1;
        end
        chk(alarmCode, exp, "alarm code");
        if (i == bound) final_report();
    endtask : wait_alarm
    task automatic alarm_effects();
        int n;
        n = 0;
        repeat (2) @(posedge clk);
        #1;
        chk({faultHi, faultLoN, motorStop}, 8'h05, "fault outputs");
        repeat (12) begin
            @(posedge clk);
            #1;
            if (supplyLed.supplyRed === 1'b1) n++;
        end
        chk(8'(n > 0), 8'h01, "red alarm blink");
    endtask : alarm_effects
    task automatic clear_alarm();
        repeat (4) @(posedge clk);
        strobe(alarmReset);
        repeat (2) @(posedge clk);
        #1;
        chk(alarmCode, 8'h00, "alarm cleared");
    endtask : clear_alarm
    // ****************************************
    // scenarios
    // ****************************************
    task automatic other_errors();
        logic [7:0] codes [6] = '{8'h88, 8'h8c, 8'h8d, 8'h89, 8'h8a, 8'h8a};
        ceam_pkg::ceam_frame_t infos [3] = '{5'b00100, 5'b00010, 5'b00001};
        logic [7:0] leds;
        for (int i = 0; i < 6; i++) begin
            @(negedge clk);
            toolPortActive = (i == 3);
            internalBusyFlag = (i == 4);
            nvMemAlarm = (i == 5);
            repeat (4) @(posedge clk);
            #1;
            leds = {commLed, supplyLed};
            send_frame(i < 3 ? infos[i] : 5'b00000);
            chk({7'h00, cmdReject}, 8'h01, "reject");
            chk(errCode, codes[i], "error code");
            @(posedge clk);
            #1;
            chk({commLed, supplyLed}, leds, "indicators unchanged");
        end
        @(negedge clk);
        nvMemAlarm = 1'b0;
    endtask : other_errors
    task automatic link_errors();
        int n;
        logic prev;
        n = 0;
        prev = 1'b0;
        conv_u.keepAlive = 1'b0;
        send_frame(5'b10000);
        chk(errCode, 8'h84, "framing error code");
        @(posedge clk);
        #1;
        chk({7'h00, commLed.commRed}, 8'h01, "comm red");
        repeat (40) begin
            if (supplyLed.supplyRed && supplyLed.supplyGreen && !prev) n++;
            prev = supplyLed.supplyRed && supplyLed.supplyGreen;
            @(posedge clk);
            #1;
        end
        chk(8'(n), 8'h02, "double blink");
        send_frame(5'b01000);
        chk(errCode, 8'h84, "check error code");
        chk(alarmCode, 8'h00, "two errors no alarm");
        send_frame(5'b10000);
        wait_alarm(8'h84, 6);
        alarm_effects();
        conv_u.keepAlive = 1'b1;
        send_frame(5'b00000);
        chk({7'h00, cmdAccept}, 8'h01, "good frame accepted");
        clear_alarm();
    endtask : link_errors
    task automatic history();
        clear_hist_and_fill();
        read_hist(4'h0, 8'h8c);
        read_hist(4'h9, 8'h88);
        read_hist(4'ha, 8'h00);
        strobe(histClear);
        @(posedge clk);
        #1;
        chk({4'h0, histCount}, 8'h00, "cleared count");
        send_frame(5'b00100);
        @(negedge clk);
        srst = 1'b1;
        repeat (3) @(negedge clk);
        srst = 1'b0;
        chk({4'h0, histCount}, 8'h00, "count after reset");
    endtask : history
    task automatic clear_hist_and_fill();
        strobe(histClear);
        for (int i = 0; i < 12; i++) send_frame(i % 2 ? 5'b00010 : 5'b00100);
        chk({4'h0, histCount}, 8'h0a, "full count");
    endtask : clear_hist_and_fill
    task automatic alarms();
        logic [7:0] codes [3] = '{8'h83, 8'h8e, 8'h81};
        for (int i = 0; i < 3; i++) begin
            @(negedge clk);
            baudSwitchValid = (i != 0);
            converterAlarm = (i == 1);
            motorRunning = (i == 2);
            masterDisconnected = (i == 2);
            wait_alarm(codes[i], 8);
            alarm_effects();
            @(negedge clk);
            baudSwitchValid = 1'b1;
            converterAlarm = 1'b0;
            masterDisconnected = 1'b0;
            clear_alarm();
        end
        repeat (300) @(posedge clk);
        #1;
        chk(alarmCode, 8'h00, "keep-alive holds off timeout");
        conv_u.keepAlive = 1'b0;
        repeat (100) @(posedge clk);
        #1;
        chk(alarmCode, 8'h00, "no timeout yet");
        wait_alarm(8'h85, 80);
        conv_u.keepAlive = 1'b1;
        send_frame(5'b00000);
        clear_alarm();
    endtask : alarms
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (20) @(negedge clk);
        srst = 1'b0;
        #1;
        chk({faultLoN, histCount, alarmCode[2:0]}, 8'h80, "reset outputs");
        other_errors();
        link_errors();
        history();
        alarms();
        final_report();
    end
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        final_report();
    end
endmodule : tb_comm_error_alarm_monitor
